/* inc/vint_defines.svh */
// register offsets, field positions and reset values of the interrupt unit
`ifndef VINT_DEFINES_SVH
`define VINT_DEFINES_SVH
`define VINT_OFS_SVR0 12'h080
`define VINT_OFS_SVR31 12'h0fc
`define VINT_OFS_IVR 12'h100
`define VINT_OFS_FVR 12'h104
`define VINT_OFS_ISR 12'h108
`define VINT_OFS_IPR 12'h10c
`define VINT_OFS_IMR 12'h110
`define VINT_OFS_CISR 12'h114
`define VINT_OFS_IECR 12'h120
`define VINT_OFS_IDCR 12'h124
`define VINT_OFS_ICCR 12'h128
`define VINT_OFS_ISCR 12'h12c
`define VINT_OFS_EOICR 12'h130
`define VINT_OFS_SPU 12'h134
`define VINT_OFS_SRCIN 12'h150
`define VINT_OFS_EVST 12'h160
`define VINT_OFS_EVEN 12'h164
`define VINT_OFS_EVCLR 12'h168
`define VINT_ID_W 5
`define VINT_FAST_BIT 0
`define VINT_LINE_FAST_BIT 0
`define VINT_LINE_NORM_BIT 1
`define VINT_EV_FAST 0
`define VINT_EV_NORM 1
`define VINT_EV_EOH 2
`define VINT_EV_W 3
`define VINT_RST_32 32'h0000_0000
`endif

/* inc/vint_pkg.sv */
// types of the interrupt unit
package vint_pkg;
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } vint_bus_s;
   typedef enum logic [0:0] {
      VINT_IDLE = 1'b0,
      VINT_BUSY = 1'b1
   } vint_state_e;
   typedef logic [4:0] vint_id_t;
endpackage

/* logic/vint_regs.sv */
// status and command registers of the vectored interrupt unit
// Functional notes
// - fast vector readback returns vector slot of source zero.
// - with no fast request, fast readback returns spurious vector.
// - current-source status returns serviced source number, rest zero.
// - pending status has one bit per source, one means pending.
// - enable-mask status shows enables in same layout.
// - line status bit0 fast line active, bit1 normal line active.
// - enable command ones set mask bits, zeros no effect.
// - disable command ones clear mask bits, zeros no effect.
// - clear command ones clear latched requests, zeros no effect.
// - set command ones make requests pending, zeros no effect.
// - any end-of-handler write ends current servicing.
// - spurious vector returned by both readbacks on spurious case.
// - normal readback returns slot of lowest-numbered pending enabled source above zero, or spurious.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "vint_defines.svh"
module vint_regs (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset, high
   input wire vint_pkg::vint_bus_s bus, // register bus request
   input wire logic [31:0] src_req, // level requests from sources
   output logic [31:0] rdata_ff, // read data, cycle after read
   output logic fast_request_line_n_ff, // fast request to core, low
   output logic normal_request_line_n_ff, // normal request to core, low
   output logic irq_ff // event interrupt, high
);
   import vint_pkg::*;

   logic [31:0] vec_mem [0:31];
   logic [31:0] spurious_handler_vector_ff;
   logic [31:0] pending_ff;
   logic [31:0] mask_ff;
   logic [31:0] req_d_ff;
   vint_id_t cur_id_ff;
   vint_state_e state_ff;
   logic [`VINT_EV_W-1:0] ev_st_ff;
   logic [`VINT_EV_W-1:0] ev_en_ff;
   logic [31:0] active;
   logic [31:0] norm_active;
   logic fast_line_state;
   logic normal_line_state;
   logic norm_any;
   vint_id_t norm_id;
   logic [31:0] nxt_rdata;
   logic [`VINT_EV_W-1:0] ev_now;

   function automatic logic is_wr(input vint_bus_s b, input logic [11:0] a);
      is_wr = b.wr && (b.addr == a);
   endfunction

   function automatic logic is_rd(input vint_bus_s b, input logic [11:0] a);
      is_rd = b.rd && (b.addr == a);
   endfunction

   function automatic vint_id_t lowest(input logic [31:0] v);
      lowest = 5'h00;
      for (int i = 31; i >= 1; i--) begin
         if (v[i]) begin
            lowest = vint_id_t'(i);
         end
      end
   endfunction

   wire logic slot_wr = bus.wr && (bus.addr >= `VINT_OFS_SVR0) &&
                        (bus.addr <= `VINT_OFS_SVR31);
   wire logic [4:0] slot_idx = bus.addr[6:2];
   wire logic eoh_wr = is_wr(bus, `VINT_OFS_EOICR);
   wire logic ivr_rd = is_rd(bus, `VINT_OFS_IVR);

   // sources pending and enabled
   assign active = pending_ff & mask_ff;
   assign norm_active = {active[31:1], 1'b0};
   assign fast_line_state = active[`VINT_FAST_BIT];
   assign normal_line_state = (state_ff == VINT_BUSY);
   assign norm_any = |norm_active;
   assign norm_id = lowest(norm_active);

   // handler vector storage
   always_ff @(posedge clk) begin
      if (slot_wr) begin
         vec_mem[slot_idx] <= bus.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         spurious_handler_vector_ff <= `VINT_RST_32;
      end else if (is_wr(bus, `VINT_OFS_SPU)) begin
         spurious_handler_vector_ff <= bus.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mask_ff <= `VINT_RST_32;
      end else if (is_wr(bus, `VINT_OFS_IECR)) begin
         mask_ff <= mask_ff | bus.wdata;
      end else if (is_wr(bus, `VINT_OFS_IDCR)) begin
         mask_ff <= mask_ff & ~bus.wdata;
      end
   end

   // rising request edge latches; set beats clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         req_d_ff <= `VINT_RST_32;
         pending_ff <= `VINT_RST_32;
      end else begin
         req_d_ff <= src_req;
         pending_ff <= (pending_ff
            & ~(is_wr(bus, `VINT_OFS_ICCR) ? bus.wdata : 32'h0000_0000)
            & ~((ivr_rd && norm_any) ? (32'h0000_0001 << norm_id)
                                      : 32'h0000_0000))
            | (src_req & ~req_d_ff)
            | (is_wr(bus, `VINT_OFS_ISCR) ? bus.wdata : 32'h0000_0000);
      end
   end

   // vector read starts servicing, end-of-handler write ends it
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= VINT_IDLE;
         cur_id_ff <= 5'h00;
      end else begin
         case (state_ff)
            VINT_IDLE: begin
               if (ivr_rd && norm_any) begin
                  state_ff <= VINT_BUSY;
                  cur_id_ff <= norm_id;
               end
            end
            VINT_BUSY: begin
               if (eoh_wr) begin
                  state_ff <= VINT_IDLE;
               end
            end
            default: state_ff <= VINT_IDLE;
         endcase
      end
   end

   // normal line held while servicing; nested levels not modelled
   always_ff @(posedge clk) begin
      if (rst) begin
         fast_request_line_n_ff <= 1'b1;
         normal_request_line_n_ff <= 1'b1;
      end else begin
         fast_request_line_n_ff <= ~fast_line_state;
         normal_request_line_n_ff <= ~(norm_any || normal_line_state);
      end
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (ivr_rd) begin
         if (norm_any) begin
            nxt_rdata = vec_mem[norm_id];
         end else begin
            nxt_rdata = spurious_handler_vector_ff;
         end
      end else if (is_rd(bus, `VINT_OFS_FVR)) begin
         if (fast_line_state) begin
            nxt_rdata = vec_mem[`VINT_FAST_BIT];
         end else begin
            nxt_rdata = spurious_handler_vector_ff;
         end
      end else if (is_rd(bus, `VINT_OFS_ISR)) begin
         nxt_rdata = {27'h0, cur_id_ff};
      end else if (is_rd(bus, `VINT_OFS_IPR)) begin
         nxt_rdata = pending_ff;
      end else if (is_rd(bus, `VINT_OFS_IMR)) begin
         nxt_rdata = mask_ff;
      end else if (is_rd(bus, `VINT_OFS_CISR)) begin
         nxt_rdata = {30'h0, ~normal_request_line_n_ff,
                      ~fast_request_line_n_ff};
      end else if (is_rd(bus, `VINT_OFS_SPU)) begin
         nxt_rdata = spurious_handler_vector_ff;
      end else if (is_rd(bus, `VINT_OFS_SRCIN)) begin
         nxt_rdata = src_req;
      end else if (is_rd(bus, `VINT_OFS_EVST)) begin
         nxt_rdata = {29'h0, ev_st_ff};
      end else if (is_rd(bus, `VINT_OFS_EVEN)) begin
         nxt_rdata = {29'h0, ev_en_ff};
      end else if (bus.rd && (bus.addr >= `VINT_OFS_SVR0) &&
                   (bus.addr <= `VINT_OFS_SVR31)) begin
         nxt_rdata = vec_mem[bus.addr[6:2]];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= `VINT_RST_32;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // sticky events: fast line rise, normal line rise, end of handler
   assign ev_now = {eoh_wr,
                    normal_request_line_n_ff & norm_any,
                    fast_request_line_n_ff & fast_line_state};

   always_ff @(posedge clk) begin
      if (rst) begin
         ev_st_ff <= 3'h0;
         ev_en_ff <= 3'h0;
         irq_ff <= 1'b0;
      end else begin
         ev_st_ff <= (ev_st_ff & ~(is_wr(bus, `VINT_OFS_EVCLR) ?
                     bus.wdata[`VINT_EV_W-1:0] : 3'h0)) | ev_now;
         if (is_wr(bus, `VINT_OFS_EVEN)) begin
            ev_en_ff <= bus.wdata[`VINT_EV_W-1:0];
         end
         irq_ff <= |(ev_st_ff & ev_en_ff);
      end
   end
endmodule // vint_regs

/* tb/vint_regs_monitor.sv */
// assertion checker bound to the interrupt unit registers
`timescale 1ns/1ps
`include "vint_defines.svh"
module vint_regs_monitor (
   input wire logic clk, // clock
   input wire logic rst, // sync reset
   input wire vint_pkg::vint_bus_s bus, // register bus
   input wire logic [31:0] src_req, // sources
   input wire logic [31:0] rdata_ff, // read data
   input wire logic fast_request_line_n_ff, // fast line
   input wire logic normal_request_line_n_ff, // normal line
   input wire logic irq_ff // event interrupt
);
   import vint_pkg::*;
   logic en_w, dis_w, clr_w, set_w, eoh_w, msk_r, pnd_r;
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   assign en_w = bus.wr && bus.addr == `VINT_OFS_IECR;
   assign dis_w = bus.wr && bus.addr == `VINT_OFS_IDCR;
   assign clr_w = bus.wr && bus.addr == `VINT_OFS_ICCR;
   assign set_w = bus.wr && bus.addr == `VINT_OFS_ISCR;
   assign eoh_w = bus.wr && bus.addr == `VINT_OFS_EOICR;
   assign msk_r = bus.rd && bus.addr == `VINT_OFS_IMR;
   assign pnd_r = bus.rd && bus.addr == `VINT_OFS_IPR;
   chk_line_status: assert property (bus.rd && bus.addr == `VINT_OFS_CISR
      |=> rdata_ff == {30'h0, ~$past(normal_request_line_n_ff),
      ~$past(fast_request_line_n_ff)}) else $error("line status");
   chk_id_width: assert property (bus.rd && bus.addr == `VINT_OFS_ISR
      |=> rdata_ff[31:5] == 27'h0) else $error("id upper bits");
   chk_quiet_read: assert property (!$past(bus.rd) |-> rdata_ff == 0)
      else $error("data without read");
   chk_mask_set: assert property (en_w ##1 msk_r |=>
      (rdata_ff & $past(bus.wdata, 2)) == $past(bus.wdata, 2)) else $error("en");
   chk_mask_clear: assert property (dis_w ##1 msk_r |=>
      (rdata_ff & $past(bus.wdata, 2)) == 0) else $error("dis");
   chk_pend_set: assert property (set_w ##1 pnd_r |=>
      (rdata_ff & $past(bus.wdata, 2)) == $past(bus.wdata, 2)) else $error("set");
   chk_pend_clear: assert property (clr_w ##1 pnd_r |=>
      (rdata_ff & $past(bus.wdata, 2)) == 0) else $error("clr");
   // a disable or clear of an idle pending source may also drop the line
   chk_eoh_release: assert property ($rose(normal_request_line_n_ff)
      && !$past(dis_w, 2) && !$past(clr_w, 2) |->
      $past(eoh_w) || $past(eoh_w, 2) || $past(eoh_w, 3)) else $error("eoh");
   cover property (eoh_w);
   cover property ($fell(fast_request_line_n_ff));
   cover property ($rose(irq_ff));
endmodule // vint_regs_monitor
bind vint_regs vint_regs_monitor chk_u (.clk, .rst, .bus, .src_req,
   .rdata_ff, .fast_request_line_n_ff, .normal_request_line_n_ff, .irq_ff);

/* tb/vint_core_model.sv */
// core-side model: samples both request lines each clock
`timescale 1ns/1ps
module vint_core_model (
   input wire logic clk, // clock
   input wire logic fast_n, // fast request, low
   input wire logic norm_n, // normal request, low
   output logic fast_seen, // core saw fast request
   output logic norm_seen // core saw normal request
);
   // one flop like the core input stage, so a glitch is never seen
   always_ff @(posedge clk) begin
      fast_seen <= !fast_n;
      norm_seen <= !norm_n;
   end
endmodule // vint_core_model

/* tb/tb_top.sv */
// self-checking bench of the interrupt unit registers
`timescale 1ns/1ps
`include "vint_defines.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
   mismatches++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_top;
   import vint_pkg::*;
   typedef struct {
      logic [11:0] wa;
      logic [31:0] wd;
      logic [11:0] ra;
      logic [31:0] ex;
   } vint_row_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   vint_bus_s bus = '0;
   logic [31:0] src_req = '0;
   logic [31:0] rdata;
   logic fast_n, norm_n, irq, fast_seen, norm_seen;
   int mismatches = 0;
   int check_count = 0;
   vint_row_s rows [11] = '{
      '{12'h118, 32'h0, `VINT_OFS_IMR, 32'h0},
      '{`VINT_OFS_IECR, 32'hf5, `VINT_OFS_IMR, 32'hf5},
      '{`VINT_OFS_IECR, 32'h8000_0000, `VINT_OFS_IMR, 32'h8000_00f5},
      '{`VINT_OFS_IDCR, 32'h11, `VINT_OFS_IMR, 32'h8000_00e4},
      '{`VINT_OFS_ISCR, 32'hc00, `VINT_OFS_IPR, 32'hc00},
      '{`VINT_OFS_ICCR, 32'hc00, `VINT_OFS_IPR, 32'h0},
      '{`VINT_OFS_SPU, 32'h1234_5670, `VINT_OFS_FVR, 32'h1234_5670},
      '{`VINT_OFS_SVR0, 32'ha000_0000, `VINT_OFS_IVR, 32'h1234_5670},
      '{12'h094, 32'h5000_0050, `VINT_OFS_FVR, 32'h1234_5670},
      '{`VINT_OFS_IPR, 32'hffff_ffff, `VINT_OFS_IPR, 32'h0},
      '{12'h118, 32'hffff_ffff, 12'h118, 32'h0}
   };
   vint_regs dut_u (.clk(clk), .rst(rst), .bus(bus), .src_req(src_req),
      .rdata_ff(rdata), .fast_request_line_n_ff(fast_n),
      .normal_request_line_n_ff(norm_n), .irq_ff(irq));
   vint_core_model core_u (.clk(clk), .fast_n(fast_n), .norm_n(norm_n),
      .fast_seen(fast_seen), .norm_seen(norm_seen));
   task automatic finish_test();
      if (mismatches == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // write, then read back to back; data is valid only in the next cycle
   task automatic wr_rd(logic [11:0] wa, logic [31:0] wd, logic [11:0] ra,
      logic [31:0] ex);
      bus <= '{wa, wd, 1'b1, 1'b0};
      @(posedge clk);
      bus <= '{ra, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      bus <= '0;
      @(posedge clk);
      `CHK("rdata", ex, rdata)
   endtask
   task automatic wait_st(logic [2:0] ex);
      int n;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if ({irq, norm_seen, fast_seen} === ex) break;
      end
      `CHK("irq_norm_fast", ex, {irq, norm_seen, fast_seen})
      if (n == 20) finish_test();
   endtask
   initial begin
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wr_rd(rows[i].wa, rows[i].wd, rows[i].ra, rows[i].ex);
      end
      wr_rd(`VINT_OFS_ISCR, 32'h20, `VINT_OFS_IPR, 32'h20);
      wait_st(3'b010);
      wr_rd(12'h118, 32'h0, `VINT_OFS_CISR, 32'h2);
      wr_rd(12'h118, 32'h0, `VINT_OFS_IVR, 32'h5000_0050);
      wr_rd(12'h118, 32'h0, `VINT_OFS_ISR, 32'h5);
      wr_rd(`VINT_OFS_EOICR, 32'hdead_beef, `VINT_OFS_IPR, 32'h0);
      wait_st(3'b000);
      wr_rd(`VINT_OFS_IECR, 32'h1, `VINT_OFS_FVR, 32'h1234_5670);
      src_req <= 32'h1;
      wait_st(3'b001);
      wr_rd(12'h118, 32'h0, `VINT_OFS_FVR, 32'ha000_0000);
      wr_rd(`VINT_OFS_ICCR, 32'h1, `VINT_OFS_IPR, 32'h0);
      wait_st(3'b000);
      wr_rd(12'h118, 32'h0, `VINT_OFS_FVR, 32'h1234_5670);
      wr_rd(`VINT_OFS_EVEN, 32'h7, `VINT_OFS_EVST, 32'h7);
      wait_st(3'b100);
      wr_rd(`VINT_OFS_EVEN, 32'h0, `VINT_OFS_EVEN, 32'h0);
      wait_st(3'b000);
      wr_rd(`VINT_OFS_EVCLR, 32'h7, `VINT_OFS_EVST, 32'h0);
      src_req <= 32'h0;
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      wr_rd(12'h118, 32'h0, `VINT_OFS_IMR, 32'h0);
      wr_rd(12'h118, 32'h0, `VINT_OFS_FVR, 32'h0);
      finish_test();
   end
endmodule // tb_top
